//--- bpc_regs.sv
// Power, option, interrupt mask and command bank of the baseband processor
// Assumes event flags come from logic on clk; pins pass two flip-flops
//
// Contract
// - A power bit written 1 enables its section, written 0 disables it.
// - Reset leaves only the clock power bit set: shutdown mode.
// - Clock bit low turns off data processor and I/O ports; keypad stays.
// - Bits 2,3,4 enable control receive, tone path, transmit path; reset 0.
// - Option bit 0 picks one or two busy/idle bits examined.
// - Option bit 1 picks eleven or five voice word repeats.
// - Option bit 2 low enables voice message auto muting.
// - Option bit 3 high enables receiver idle power saving.
// - Mask word one bits 0..6 enable seven interrupt sources.
// - Mask word two bits 0..7 enable eight interrupt sources.
// - Commence write runs precursor, then buffer available, then sending.
// - Watchdog restart write starts one cycle expiring after 1.5 seconds.
// - Expiry drives output low 100 ms and holds radio gate off.
// - Halt write stops transmission at once, buffer kept.
// - Drain write ends transmission once the fifth repeat starts.
// - Sync restart write resets data recovery to fast lock at once.
// - An event interrupts only when its mask bit is set.
// - Polarity input selects interrupt high active or low active.
`timescale 1ns/1ps
`include "bpc_defs.svh"

module bpc_regs
	import bpc_pkg::*;
#(
	parameter logic [31:0] WDOG_CYCLES = `BPC_WDOG_TIMEOUT_MS * `BPC_CLK_KHZ,
	parameter logic [31:0] EXPIRY_CYCLES = `BPC_EXPIRY_MS * `BPC_CLK_KHZ
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_mosi,
	input wire logic interrupt_active_low,
	input wire logic [6:0] event_flags_one,
	input wire logic [7:0] event_flags_two,
	output logic clock_power_en,
	output logic security_bit,
	output logic data_proc_en,
	output logic fwd_ctl_rx_en,
	output logic tone_path_en,
	output logic tx_speech_en,
	output logic busy_idle_two_bits,
	output logic voice_repeats_five,
	output logic auto_mute_off,
	output logic receiver_idle_power_saving,
	output logic interrupt_out,
	output logic watchdog_expiry_out_b,
	output logic tx_radio_gate,
	output logic bit_sync_restart_pulse,
	output logic tx_busy,
	output logic tx_buf_avail_pulse,
	output logic tx_done_pulse,
	output logic [3:0] tx_repeat_index
);

	logic [1:0] rst_sync_q;
	logic rst_sync_b;
	bpc_core_s q;
	bpc_core_s d;
	bpc_wr_if wr();

	// True when any flag has its enable bit set
	function automatic logic masked_any(input logic [7:0] flags, input logic [7:0] mask);
		masked_any = |(flags & mask);
	endfunction

	// Address match on a write strobe
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
		hit = wr.stb && (addr == want);
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_sync_q[1];

	// Serial write port
	bpc_spi_port u_spi (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.spi_sclk(spi_sclk),
		.spi_cs_b(spi_cs_b),
		.spi_mosi(spi_mosi),
		.wr(wr)
	);

	// Next-state logic for the whole bank
	always_comb begin
		d = q;
		d.sync_pulse = 1'b0;
		d.buf_avail = 1'b0;
		d.tx_done = 1'b0;

		// Data registers: power word, options, masks
		if (hit(wr.addr, `BPC_ADDR_POWER)) begin
			d.pwr = wr.data[4:0];
		end
		if (hit(wr.addr, `BPC_ADDR_OPT)) begin
			d.opt = wr.data[3:0];
		end
		if (hit(wr.addr, `BPC_ADDR_MASK1)) begin
			d.mask1 = wr.data[6:0];
		end
		if (hit(wr.addr, `BPC_ADDR_MASK2)) begin
			d.mask2 = wr.data;
		end

		// Section enables; every section dies with the clock bit
		d.sect[0] = d.pwr[`BPC_PWR_CLK];
		d.sect[1] = d.pwr[`BPC_PWR_CLK] & d.pwr[`BPC_PWR_FWD];
		d.sect[2] = d.pwr[`BPC_PWR_CLK] & d.pwr[`BPC_PWR_TONE];
		d.sect[3] = d.pwr[`BPC_PWR_CLK] & d.pwr[`BPC_PWR_TX];

		// Interrupt level with selectable polarity
		d.pol_s = {q.pol_s[0], interrupt_active_low};
		d.irq = (masked_any({1'b0, event_flags_one}, {1'b0, q.mask1})
			| masked_any(event_flags_two, q.mask2)) ^ q.pol_s[1];

		// Bit sync restart: one-cycle strobe, data ignored
		if (hit(wr.addr, `BPC_ADDR_SYNC)) begin
			d.sync_pulse = 1'b1;
		end

		// Watchdog cycle counter
		if (q.wd_run) begin
			if (q.wd_cnt == WDOG_CYCLES - 32'h1) begin
				d.wd_run = 1'b0;
				d.wd_cnt = 32'h0;
				d.exp_cnt = EXPIRY_CYCLES;
				d.wd_out = 1'b0;
				d.rf_gate = 1'b0;
			end else begin
				d.wd_cnt = q.wd_cnt + 32'h1;
			end
		end

		// Expiry pulse length
		if (q.exp_cnt != 32'h0) begin
			d.exp_cnt = q.exp_cnt - 32'h1;
			if (q.exp_cnt == 32'h1) begin
				d.wd_out = 1'b1;
			end
		end

		// Restart in an expiry cycle rearms the count and reopens the gate; the expiry pulse still runs
		if (hit(wr.addr, `BPC_ADDR_WDOG)) begin
			d.wd_run = 1'b1;
			d.wd_cnt = 32'h0;
			d.rf_gate = 1'b1;
		end

		// Transmit sequencer
		case (q.tx_state)
			TX_IDLE: begin
				d.tx_cnt = 32'h0;
			end
			TX_PRECURSOR: begin
				if (q.tx_cnt == `BPC_PRECURSOR_CYC - 32'h1) begin
					d.tx_state = TX_SEND;
					d.buf_avail = 1'b1; // Buffer taken by encoder
					d.tx_cnt = 32'h0;
					d.rep_idx = 4'h0;
				end else begin
					d.tx_cnt = q.tx_cnt + 32'h1;
				end
			end
			TX_SEND: begin
				// A pending drain lets the fifth repeat begin, then ends the sequence
				if (q.drain_pend && q.rep_idx >= `BPC_REP_FIFTH) begin
					d.tx_state = TX_IDLE;
					d.tx_done = 1'b1;
				end else if (q.tx_cnt == `BPC_WORD_CYC - 32'h1) begin
					d.tx_cnt = 32'h0;
					d.rep_idx = q.rep_idx + 4'h1;
					if (q.rep_idx + 4'h1 == (q.opt[`BPC_OPT_REP5] ? `BPC_REP_SHORT
						: `BPC_REP_LONG)) begin
						d.tx_state = TX_IDLE;
						d.tx_done = 1'b1;
					end
				end else begin
					d.tx_cnt = q.tx_cnt + 32'h1;
				end
			end
			default: begin
				d.tx_state = TX_IDLE;
			end
		endcase

		// Drain: stop now if the fifth repeat has begun, else at its start
		if (hit(wr.addr, `BPC_ADDR_TX_DRAIN) && q.tx_state != TX_IDLE) begin
			if (q.tx_state == TX_SEND && q.rep_idx >= `BPC_REP_FIFTH) begin
				d.tx_state = TX_IDLE;
				d.tx_done = 1'b1;
			end else begin
				d.drain_pend = 1'b1;
			end
		end

		// Commence: start a fresh precursor
		if (hit(wr.addr, `BPC_ADDR_TX_START)) begin
			d.tx_state = TX_PRECURSOR;
			d.tx_cnt = 32'h0;
			d.rep_idx = 4'h0;
			d.drain_pend = 1'b0;
			d.buf_avail = 1'b0;
			d.tx_done = 1'b0;
		end

		// Halt: immediate stop, buffer untouched
		if (hit(wr.addr, `BPC_ADDR_TX_HALT)) begin
			d.tx_state = TX_IDLE;
			d.tx_cnt = 32'h0;
			d.drain_pend = 1'b0;
			d.buf_avail = 1'b0;
			d.tx_done = 1'b0;
		end

		if (d.tx_state == TX_IDLE) begin
			d.drain_pend = 1'b0;
		end
	end

	// State register; reset gives shutdown mode
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= '{
				pwr: `BPC_PWR_RESET,
				sect: 4'h1,
				opt: `BPC_OPT_RESET,
				mask1: `BPC_MASK1_RESET,
				mask2: `BPC_MASK2_RESET,
				pol_s: 2'b00,
				irq: 1'b0,
				wd_run: 1'b0,
				wd_cnt: 32'h0,
				exp_cnt: 32'h0,
				wd_out: 1'b1,
				rf_gate: 1'b1,
				sync_pulse: 1'b0,
				tx_state: TX_IDLE,
				tx_cnt: 32'h0,
				rep_idx: 4'h0,
				drain_pend: 1'b0,
				buf_avail: 1'b0,
				tx_done: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign clock_power_en = q.pwr[`BPC_PWR_CLK];
	assign security_bit = q.pwr[`BPC_PWR_SEC];
	assign data_proc_en = q.sect[0];
	assign fwd_ctl_rx_en = q.sect[1];
	assign tone_path_en = q.sect[2];
	assign tx_speech_en = q.sect[3];
	assign busy_idle_two_bits = q.opt[`BPC_OPT_BUSY2];
	assign voice_repeats_five = q.opt[`BPC_OPT_REP5];
	assign auto_mute_off = q.opt[`BPC_OPT_MUTE_OFF];
	assign receiver_idle_power_saving = q.opt[`BPC_OPT_IDLE_SAVE];
	assign interrupt_out = q.irq;
	assign watchdog_expiry_out_b = q.wd_out;
	assign tx_radio_gate = q.rf_gate;
	assign bit_sync_restart_pulse = q.sync_pulse;
	assign tx_busy = (q.tx_state != TX_IDLE);
	assign tx_buf_avail_pulse = q.buf_avail;
	assign tx_done_pulse = q.tx_done;
	assign tx_repeat_index = q.rep_idx;

endmodule

//--- bpc_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 200 MHz core clock and 8-bit serial register writes
`ifndef BPC_DEFS_SVH
`define BPC_DEFS_SVH

// Write addresses
`define BPC_ADDR_POWER 8'h03
`define BPC_ADDR_OPT 8'h04
`define BPC_ADDR_MASK1 8'h05
`define BPC_ADDR_MASK2 8'h06
`define BPC_ADDR_TX_START 8'h08
`define BPC_ADDR_WDOG 8'h09
`define BPC_ADDR_TX_HALT 8'h0A
`define BPC_ADDR_TX_DRAIN 8'h0B
`define BPC_ADDR_SYNC 8'h0C

// Power word fields
`define BPC_PWR_CLK 0
`define BPC_PWR_SEC 1
`define BPC_PWR_FWD 2
`define BPC_PWR_TONE 3
`define BPC_PWR_TX 4

// Optional control fields
`define BPC_OPT_BUSY2 0
`define BPC_OPT_REP5 1
`define BPC_OPT_MUTE_OFF 2
`define BPC_OPT_IDLE_SAVE 3

// Reset values
`define BPC_PWR_RESET 5'h01
`define BPC_OPT_RESET 4'h0
`define BPC_MASK1_RESET 7'h00
`define BPC_MASK2_RESET 8'h00

// Timing
`define BPC_CLK_KHZ 200000
`define BPC_WDOG_TIMEOUT_MS 1500
`define BPC_EXPIRY_MS 100
`define BPC_PRECURSOR_CYC 32'h0000_0030
`define BPC_WORD_CYC 32'h0000_0028
`define BPC_REP_LONG 4'hB
`define BPC_REP_SHORT 4'h5
`define BPC_REP_FIFTH 4'h4
`define BPC_SPI_BITS 5'h10

`endif

//--- bpc_pkg.sv
// Types shared by the register bank and its serial write port
// Assumes bpc_defs.svh is on the include path
package bpc_pkg;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_PRECURSOR,
		TX_SEND
	} bpc_tx_e;

	// Serial write port state
	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] cs_s;
		logic [1:0] mosi_s;
		logic [15:0] shift;
		logic [4:0] nbits;
		logic stb;
		logic [7:0] addr;
		logic [7:0] data;
	} bpc_spi_s;

	// Register bank state
	typedef struct packed {
		logic [4:0] pwr;
		logic [3:0] sect;
		logic [3:0] opt;
		logic [6:0] mask1;
		logic [7:0] mask2;
		logic [1:0] pol_s;
		logic irq;
		logic wd_run;
		logic [31:0] wd_cnt;
		logic [31:0] exp_cnt;
		logic wd_out;
		logic rf_gate;
		logic sync_pulse;
		bpc_tx_e tx_state;
		logic [31:0] tx_cnt;
		logic [3:0] rep_idx;
		logic drain_pend;
		logic buf_avail;
		logic tx_done;
	} bpc_core_s;

endpackage

//--- bpc_wr_if.sv
// Write strobe carrier between the serial port and the register bank
// Assumes both ends share the core clock
`timescale 1ns/1ps

interface bpc_wr_if;
	logic stb;
	logic [7:0] addr;
	logic [7:0] data;

	modport port (output stb, output addr, output data);
	modport bank (input stb, input addr, input data);
endinterface

//--- bpc_spi_port.sv
// Serial write port: 8-bit address then 8-bit data, MSB first, while cs low
// Assumes sclk is far slower than clk; pins are synchronised here
`timescale 1ns/1ps
`include "bpc_defs.svh"

module bpc_spi_port
	import bpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_sync_b,
	input wire logic spi_sclk,
	input wire logic spi_cs_b,
	input wire logic spi_mosi,
	bpc_wr_if.port wr
);

	bpc_spi_s q;
	bpc_spi_s d;

	// Synchronise pins, shift on sclk rising edge, commit on the sixteenth bit
	always_comb begin
		d = q;
		d.stb = 1'b0;
		d.sclk_s = {q.sclk_s[1:0], spi_sclk};
		d.cs_s = {q.cs_s[0], spi_cs_b};
		d.mosi_s = {q.mosi_s[0], spi_mosi};
		if (q.cs_s[1]) begin
			d.nbits = 5'h00; // Deselect drops a partial frame
		end else if (q.sclk_s[1] && !q.sclk_s[2]) begin
			d.shift = {q.shift[14:0], q.mosi_s[1]};
			if (q.nbits == `BPC_SPI_BITS - 5'h01) begin
				d.stb = 1'b1;
				d.addr = q.shift[14:7];
				d.data = {q.shift[6:0], q.mosi_s[1]};
				d.nbits = 5'h00;
			end else begin
				d.nbits = q.nbits + 5'h01;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= '{sclk_s: 3'h0, cs_s: 2'h3, mosi_s: 2'h0, shift: 16'h0000,
				nbits: 5'h00, stb: 1'b0, addr: 8'h00, data: 8'h00};
		end else begin
			q <= d;
		end
	end

	assign wr.stb = q.stb;
	assign wr.addr = q.addr;
	assign wr.data = q.data;

endmodule

//--- bpc_props.sv
// Port checks for the power, mask and command bank
// Assumes a bind onto bpc_regs; sees its ports only
`timescale 1ns/1ps

module bpc_props #(
	parameter logic [31:0] WDOG_CYCLES = 32'h0000_00C8,
	parameter logic [31:0] EXPIRY_CYCLES = 32'h0000_0032
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic interrupt_active_low,
	input wire logic [6:0] event_flags_one,
	input wire logic [7:0] event_flags_two,
	input wire logic clock_power_en,
	input wire logic data_proc_en,
	input wire logic fwd_ctl_rx_en,
	input wire logic tone_path_en,
	input wire logic tx_speech_en,
	input wire logic interrupt_out,
	input wire logic watchdog_expiry_out_b,
	input wire logic tx_radio_gate,
	input wire logic bit_sync_restart_pulse,
	input wire logic tx_busy,
	input wire logic tx_buf_avail_pulse,
	input wire logic tx_done_pulse,
	input wire logic [3:0] tx_repeat_index
);
	logic [31:0] lo_q;

	// Length of the current expiry pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) lo_q <= '0;
		else lo_q <= watchdog_expiry_out_b ? '0 : lo_q + 1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_once(x);
		x ##1 !x;
	endsequence
	sequence s_quiet;
		(event_flags_one == 7'h00 && event_flags_two == 8'h00 && $stable(interrupt_active_low))[*4];
	endsequence

	sync_once_a: assert property (bit_sync_restart_pulse |-> s_once(bit_sync_restart_pulse))
		else $error("sync restart pulse too long");
	avail_busy_a: assert property (tx_buf_avail_pulse |-> tx_busy ##0 s_once(tx_buf_avail_pulse))
		else $error("buffer available pulse bad");
	done_end_a: assert property (tx_done_pulse |=> !tx_done_pulse && !tx_busy)
		else $error("done pulse without end");
	rep_max_a: assert property (tx_busy |-> tx_repeat_index <= 4'hA)
		else $error("too many repeats");
	proc_clk_a: assert property (data_proc_en == clock_power_en)
		else $error("data processor not tied to clock");
	sect_clk_a: assert property ((fwd_ctl_rx_en || tone_path_en || tx_speech_en) |-> clock_power_en)
		else $error("section on without clock");
	irq_idle_a: assert property (s_quiet |=> interrupt_out == interrupt_active_low)
		else $error("interrupt without event");
	exp_gate_a: assert property ($fell(watchdog_expiry_out_b) |-> ##[0:1] !tx_radio_gate)
		else $error("radio gate open on expiry");
	exp_len_a: assert property ($rose(watchdog_expiry_out_b) |-> lo_q == EXPIRY_CYCLES)
		else $error("expiry pulse length wrong");
endmodule

//--- bpc_host.sv
// Host model: writes address then data, MSB first, mode 0
// Assumes sclk phases of four core clocks; sclk stands still between frames
`timescale 1ns/1ps

module bpc_host (
	input wire logic clk,
	output logic spi_sclk,
	output logic spi_cs_b,
	output logic spi_mosi
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_b = 1'b1;
		spi_mosi = 1'b0;
	end

	// One whole write frame
	task send(input logic [7:0] a, input logic [7:0] d);
		logic [15:0] w;
		w = {a, d};
		@(posedge clk);
		#1 spi_cs_b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = w[i];
			repeat (4) @(posedge clk);
			#1 spi_sclk = 1'b1;
			repeat (4) @(posedge clk);
			#1 spi_sclk = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 spi_cs_b = 1'b1;
		spi_mosi = ~spi_mosi; // Released line shows no stale bit
	endtask
endmodule

//--- bpc_regs_test.sv
// Self-checking bench for the bank, driven through the host model
// Assumes short watchdog counts given as parameters
`timescale 1ns/1ps

module bpc_regs_test;
	localparam logic [31:0] WD = 32'h0000_00C8;
	localparam logic [31:0] EX = 32'h0000_0032;
	logic clk, rst_b, spi_sclk, spi_cs_b, spi_mosi, interrupt_active_low;
	logic [6:0] event_flags_one, m1;
	logic [7:0] event_flags_two, m2;
	logic clock_power_en, security_bit, data_proc_en, fwd_ctl_rx_en, tone_path_en;
	logic tx_speech_en, busy_idle_two_bits, voice_repeats_five, auto_mute_off;
	logic receiver_idle_power_saving, interrupt_out, watchdog_expiry_out_b, tx_radio_gate;
	logic bit_sync_restart_pulse, tx_busy, tx_buf_avail_pulse, tx_done_pulse;
	logic [3:0] tx_repeat_index;
	logic [31:0] seed = 32'h0000_1779, r;
	logic [7:0] modes [6] = '{8'h02, 8'h01, 8'h05, 8'h09, 8'h15, 8'h1D};
	int mismatches = 0, n_checks = 0, sync_n = 0, done_n = 0, avail_n = 0, max_idx = 0;
	int i, k, d0, a0;
	wire logic [7:0] pwr_v = {3'h0, tx_speech_en, tone_path_en, fwd_ctl_rx_en, security_bit,
		clock_power_en};
	wire logic [7:0] opt_v = {4'h0, receiver_idle_power_saving, auto_mute_off,
		voice_repeats_five, busy_idle_two_bits};

	bpc_host host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi));
	bpc_regs #(.WDOG_CYCLES(WD), .EXPIRY_CYCLES(EX)) DUT (.*);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Pulse counters and deepest repeat seen
	always @(posedge clk) begin
		if (bit_sync_restart_pulse === 1'b1) sync_n++;
		if (tx_done_pulse === 1'b1) done_n++;
		if (tx_buf_avail_pulse === 1'b1) avail_n++;
		if (tx_busy === 1'b1 && tx_repeat_index > max_idx) max_idx = tx_repeat_index;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] pw(input logic [7:0] v);
		return {3'h0, v[4] & v[0], v[3] & v[0], v[2] & v[0], v[1], v[0]};
	endfunction

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task tmo(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			close_out();
		end
	endtask
	task settle();
		repeat (6) @(negedge clk);
	endtask

	initial begin
		rst_b = 1'b0;
		interrupt_active_low = 1'b0;
		event_flags_one = '0;
		event_flags_two = '0;
		repeat (8) @(posedge clk);
		#1 rst_b = 1'b1;
		settle();
		chk("power", 8'h01, pwr_v);
		chk("options", 8'h00, opt_v);
		chk("watchdog", 8'h03, {watchdog_expiry_out_b, tx_radio_gate});
		$display("test reset done");
		// Every permitted power mode, host keeps security bit inverse
		for (k = 0; k < 6; k++) begin
			host.send(8'h03, modes[k]);
			settle();
			chk("power", pw(modes[k]), pwr_v);
			chk("dataproc", {7'h0, modes[k][0]}, {7'h0, data_proc_en});
		end
		$display("test power done");
		// Options, with an unmapped write that must change nothing
		for (k = 0; k < 6; k++) begin
			r = rnd();
			host.send(8'h04, r[7:0]);
			host.send(8'h07, ~r[7:0]);
			settle();
			chk("options", {4'h0, r[3:0]}, opt_v);
		end
		$display("test options done");
		// Masks, flags and polarity; first pass all masked
		for (k = 0; k < 10; k++) begin
			r = rnd();
			m1 = k ? r[6:0] & r[22:16] : 7'h00;
			m2 = k ? r[15:8] & r[31:24] : 8'h00;
			host.send(8'h05, {1'b1, m1});
			host.send(8'h06, m2);
			r = rnd();
			@(posedge clk);
			#1 event_flags_one = r[6:0] | r[22:16];
			event_flags_two = r[15:8] | r[31:24];
			interrupt_active_low = k[1];
			settle();
			chk("irq", {7'h0, ((|(event_flags_one & m1)) | (|(event_flags_two & m2)))
				^ interrupt_active_low}, {7'h0, interrupt_out});
		end
		@(posedge clk);
		#1 event_flags_one = '0;
		event_flags_two = '0;
		interrupt_active_low = 1'b0;
		$display("test interrupt done");
		// Back-to-back sync restarts, one pulse each
		d0 = sync_n;
		host.send(8'h0C, rnd());
		host.send(8'h0C, rnd());
		settle();
		chk("sync", 8'h02, sync_n - d0);
		$display("test sync done");
		// Full sequences with eleven and then five repeats
		for (k = 0; k < 2; k++) begin
			host.send(8'h04, k ? 8'h02 : 8'h00);
			max_idx = 0;
			a0 = avail_n;
			d0 = done_n;
			host.send(8'h08, rnd());
			for (i = 0; i < 4000 && done_n == d0; i++) @(negedge clk);
			tmo(i, 4000);
			chk("avail", 8'h01, avail_n - a0);
			chk("repeats", k ? 8'h04 : 8'h0A, max_idx);
		end
		// Halt mid-sequence: no done pulse
		d0 = done_n;
		host.send(8'h08, 8'h00);
		host.send(8'h0A, 8'hFF);
		settle();
		chk("halt", 8'h00, {7'h0, tx_busy});
		chk("halt done", 8'h00, done_n - d0);
		// Drain early in the sequence stops as repeat five begins
		host.send(8'h04, 8'h00);
		max_idx = 0;
		d0 = done_n;
		host.send(8'h08, 8'h00);
		host.send(8'h0B, 8'h33);
		for (i = 0; i < 4000 && done_n == d0; i++) @(negedge clk);
		tmo(i, 4000);
		chk("drain", 8'h04, max_idx);
		$display("test transmit done");
		// Timely restarts keep the watchdog quiet
		for (k = 0; k < 3; k++) host.send(8'h09, rnd());
		chk("wd kept", 8'h03, {watchdog_expiry_out_b, tx_radio_gate});
		for (i = 0; i < 400 && watchdog_expiry_out_b; i++) @(negedge clk);
		tmo(i, 400);
		chk("gate off", 8'h00, {7'h0, tx_radio_gate});
		for (i = 0; i < 200 && !watchdog_expiry_out_b; i++) @(negedge clk);
		chk("expiry", EX[7:0], i[7:0]);
		chk("gate held", 8'h00, {7'h0, tx_radio_gate});
		host.send(8'h09, 8'h00);
		settle();
		chk("gate on", 8'h01, {7'h0, tx_radio_gate});
		$display("test watchdog done");
		close_out();
	end
endmodule

bind bpc_regs bpc_props #(.WDOG_CYCLES(WDOG_CYCLES), .EXPIRY_CYCLES(EXPIRY_CYCLES)) props (.*);
